//--- rtl/indirect_table_access_map_pkg.sv
// Purpose: Constants, types and decode for the switch register bank and indirect map.
// Assumes: Byte-wide register port fed by the serial management decoder.
// Notes:   Offsets, reset values and ranges live here only.
// Behaviour
// - Queue 3 rate code, bits 6-0, resets zero.
// - Four-queue mode makes queue 3 highest priority.
// - Test registers read fixed values, host leaves them.
// - Highest queue limited exactly by its rate code.
// - Lower queues follow priority ratio registers.
// - Static MAC entries 0-31 at 0x000-0x01F.
// - VLAN buckets up to 0x1FF, four entries each.
// - Dynamic MAC table entries selected by selector 10.
// - MIB blocks: ports 1-3, reserved, port 4.
// - Total byte and drop counters from 0x100.
// - Control bits 1-0 give address bits 9-8.
// - EEE space: six registers 00-05 per port.
// - EEE, ACL, config data pass indirect byte register.
// - ACL: sixteen entries, two addresses each.
// - Function selects 011, 101 are factory reserved.
// - Config space: port 0 global, 1-3 ports.
package indirect_table_access_map_pkg;
   localparam int          NUM_PORTS      = 4;
   localparam logic [7:0]  OFS_IND_CTRL   = 8'h6E;
   localparam logic [7:0]  OFS_IND_ADDR   = 8'h6F;
   localparam logic [7:0]  OFS_IND_DATA   = 8'hA0;
   localparam logic [7:0]  OFS_TEST_A     = 8'hBF;
   localparam logic [7:0]  OFS_TEST_RSV   = 8'hCF;
   localparam logic [7:0]  OFS_TEST_B     = 8'hDF;
   localparam logic [7:0]  OFS_TEST_C     = 8'hEF;
   localparam logic [7:0]  OFS_TEST_D     = 8'hFF;
   localparam logic [7:0]  OFS_Q3_RATE [NUM_PORTS] = '{8'hBE, 8'hCE, 8'hDE, 8'hFE};
   localparam logic [7:0]  RST_TEST_A     = 8'h80;
   localparam logic [7:0]  RST_TEST_RSV   = 8'h15;
   localparam logic [7:0]  RST_TEST_B     = 8'h0C;
   localparam logic [7:0]  RST_TEST_C     = 8'h32;
   localparam logic [7:0]  RST_TEST_D     = 8'h00;
   localparam logic [6:0]  RST_Q3_RATE    = 7'h00;
   localparam logic [7:0]  RST_BYTE       = 8'h00;
   localparam int          CTRL_FS_MSB    = 7;
   localparam int          CTRL_FS_LSB    = 5;
   localparam int          CTRL_READ_BIT  = 4;
   localparam int          CTRL_TS_MSB    = 3;
   localparam int          CTRL_TS_LSB    = 2;
   localparam logic [9:0]  STATIC_LAST    = 10'h01F;
   localparam logic [9:0]  TABLE_LAST     = 10'h1FF;
   localparam logic [9:0]  MIB_RSV_FIRST  = 10'h060;
   localparam logic [9:0]  MIB_RSV_LAST   = 10'h07F;
   localparam logic [9:0]  MIB_P4_LAST    = 10'h09F;
   localparam logic [9:0]  MIB_TOT_FIRST  = 10'h100;
   localparam logic [9:0]  MIB_TOT_LAST   = 10'h113;
   localparam logic [7:0]  EEE_LAST       = 8'h05;
   localparam logic [7:0]  ACL_LAST       = 8'h1F;
   localparam logic [3:0]  CFG_PORT_LAST  = 4'h3;
   localparam logic [3:0]  PORT_LAST      = 4'h4;

   typedef enum logic [2:0] {
      FS_TABLE = 3'b000, FS_EEE = 3'b001, FS_ACL = 3'b010, FS_FACT1 = 3'b011,
      FS_CONFIG = 3'b100, FS_FACT2 = 3'b101, FS_UNUSED1 = 3'b110, FS_UNUSED2 = 3'b111
   } func_sel_t;

   typedef enum logic [3:0] {
      SP_NONE = 4'h0, SP_STATIC = 4'h1, SP_VLAN = 4'h2, SP_DYNAMIC = 4'h3,
      SP_MIB_PORT = 4'h4, SP_MIB_TOTAL = 4'h5, SP_EEE = 4'h6, SP_ACL = 4'h7,
      SP_CONFIG = 4'h8
   } space_t;

   typedef struct packed {
      space_t      space;
      logic        write;
      logic [3:0]  port;
      logic [9:0]  index;
      logic [7:0]  wdata;
   } ind_req_t;

   typedef struct packed {
      logic [6:0]  q3Rate;
      logic        q3Highest;
      logic        lowerFromRatio;
   } egress_cfg_t;

   // Maps the control byte and low address byte to a target space and entry.
   function automatic ind_req_t decodeIndirect(input logic [7:0] ctrl, input logic [7:0] low);
      ind_req_t   r;
      logic [9:0] a;
      logic [3:0] pn;
      r  = '0;
      a  = {ctrl[1:0], low};
      pn = ctrl[3:0];
      unique case (func_sel_t'(ctrl[CTRL_FS_MSB:CTRL_FS_LSB]))
         FS_TABLE: begin
            r.index = a;
            unique case (ctrl[CTRL_TS_MSB:CTRL_TS_LSB])
               2'b00: r.space = (a <= STATIC_LAST) ? SP_STATIC : SP_NONE;
               2'b01: r.space = (a <= TABLE_LAST) ? SP_VLAN : SP_NONE;
               2'b10: r.space = (a <= TABLE_LAST) ? SP_DYNAMIC : SP_NONE;
               2'b11: begin
                  if (a <= MIB_P4_LAST && !(a >= MIB_RSV_FIRST && a <= MIB_RSV_LAST)) begin
                     r.space = SP_MIB_PORT;
                     r.port  = (a[7]) ? PORT_LAST : {2'b00, a[6:5]} + 4'h1;
                  end else if (a >= MIB_TOT_FIRST && a <= MIB_TOT_LAST) begin
                     r.space = SP_MIB_TOTAL;
                  end
               end
            endcase
         end
         FS_EEE: begin
            r.port  = pn;
            r.index = {2'b00, low};
            if (low <= EEE_LAST && pn != 4'h0 && pn <= PORT_LAST) r.space = SP_EEE;
         end
         FS_ACL: begin
            r.port  = pn;
            r.index = {2'b00, low};
            if (low <= ACL_LAST && pn != 4'h0 && pn <= PORT_LAST) r.space = SP_ACL;
         end
         FS_CONFIG: begin
            r.port  = pn;
            r.index = {2'b00, low};
            if (pn <= CFG_PORT_LAST) r.space = SP_CONFIG;
         end
         FS_FACT1, FS_FACT2, FS_UNUSED1, FS_UNUSED2: r.space = SP_NONE;
      endcase
      return r;
   endfunction : decodeIndirect
endpackage : indirect_table_access_map_pkg

//--- rtl/indirect_table_access_map.sv
// Purpose: Byte register bank with queue 3 egress limits, test registers and
//          the indirect access decoder steering accesses to table engines.
// Assumes: regRead/regWrite are one-cycle strobes from the serial port decoder.
// Notes:   Writing the indirect address byte launches one indirect access.
`timescale 1ns/10ps
module indirect_table_access_map
   import indirect_table_access_map_pkg::*;
(
   input  wire logic               sys_clk,
   input  wire logic               nrst,
   input  wire logic [7:0]         regAddr,
   input  wire logic [7:0]         regWdata,
   input  wire logic               regWrite,
   input  wire logic               regRead,
   output logic      [7:0]         regRdata,
   output logic                    regRvalid,
   output ind_req_t                indReq,
   output logic                    indReqValid,
   input  wire logic [7:0]         indRdata,
   input  wire logic               indRdValid,
   input  wire logic [NUM_PORTS-1:0] fourQueueMode,
   input  wire logic [NUM_PORTS-1:0] multiQueue,
   output egress_cfg_t [NUM_PORTS-1:0] egressCfg
);

   logic [7:0]            ctrlReg, ctrlNext;
   logic [7:0]            addrReg, addrNext;
   logic [7:0]            dataReg, dataNext;
   logic [7:0]            rdReg, rdNext;
   logic                  rvReg, rvNext;
   ind_req_t              reqReg, reqNext;
   logic                  reqVReg, reqVNext;
   logic                  pendReg, pendNext;
   logic [6:0]            q3Reg [NUM_PORTS];
   logic [6:0]            q3Next [NUM_PORTS];
   egress_cfg_t [NUM_PORTS-1:0] egReg, egNext;
   ind_req_t              launch;
   logic                  launchNow;

   assign launch    = decodeIndirect(ctrlReg, regWdata);
   assign launchNow = regWrite && regAddr == OFS_IND_ADDR;

   // Queue 3 rate codes, one per port; the 0xEE slot between 0xDE and 0xFE is skipped in the map.
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PORTS; gp++) begin : g_q3
         always_comb begin
            q3Next[gp] = q3Reg[gp];
            if (regWrite && regAddr == OFS_Q3_RATE[gp]) begin
               q3Next[gp] = regWdata[6:0];
            end
            egNext[gp].q3Rate         = q3Reg[gp];
            egNext[gp].q3Highest      = fourQueueMode[gp];
            egNext[gp].lowerFromRatio = multiQueue[gp];
         end
         always_ff @(posedge sys_clk) begin
            if (!nrst) begin
               q3Reg[gp] <= RST_Q3_RATE;
               egReg[gp] <= '0;
            end else begin
               q3Reg[gp] <= q3Next[gp];
               egReg[gp] <= egNext[gp];
            end
         end
      end
   endgenerate

   assign egressCfg = egReg;

   // Control, address and data bytes, and the indirect launch.
   always_comb begin
      ctrlNext = ctrlReg;
      addrNext = addrReg;
      dataNext = dataReg;
      reqNext  = reqReg;
      reqVNext = 1'b0;
      pendNext = pendReg;
      if (regWrite && regAddr == OFS_IND_CTRL) begin
         ctrlNext = regWdata;
      end
      if (regWrite && regAddr == OFS_IND_DATA) begin
         dataNext = regWdata;
      end
      if (indRdValid && pendReg) begin
         dataNext = indRdata;
         pendNext = 1'b0;
      end
      if (launchNow) begin
         addrNext       = regWdata;
         reqNext        = launch;
         reqNext.write  = !ctrlReg[CTRL_READ_BIT];
         reqNext.wdata  = dataReg;
         if (launch.space == SP_NONE) begin
            // A reserved range never reaches an engine; a read returns zero.
            if (ctrlReg[CTRL_READ_BIT]) begin
               dataNext = RST_BYTE;
            end
            pendNext = 1'b0;
         end else begin
            reqVNext = 1'b1;
            pendNext = ctrlReg[CTRL_READ_BIT];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ctrlReg <= RST_BYTE;
         addrReg <= RST_BYTE;
         dataReg <= RST_BYTE;
         reqReg  <= '0;
         reqVReg <= 1'b0;
         pendReg <= 1'b0;
      end else begin
         ctrlReg <= ctrlNext;
         addrReg <= addrNext;
         dataReg <= dataNext;
         reqReg  <= reqNext;
         reqVReg <= reqVNext;
         pendReg <= pendNext;
      end
   end

   assign indReq      = reqReg;
   assign indReqValid = reqVReg;

   // Register read path; the answer is registered, one cycle after the strobe.
   always_comb begin
      rdNext = rdReg;
      rvNext = 1'b0;
      if (regRead) begin
         rvNext = 1'b1;
         rdNext = RST_BYTE;
         unique case (regAddr)
            OFS_IND_CTRL: rdNext = ctrlReg;
            OFS_IND_ADDR: rdNext = addrReg;
            OFS_IND_DATA: rdNext = dataReg;
            OFS_TEST_A:   rdNext = RST_TEST_A;
            OFS_TEST_RSV: rdNext = RST_TEST_RSV;
            OFS_TEST_B:   rdNext = RST_TEST_B;
            OFS_TEST_C:   rdNext = RST_TEST_C;
            OFS_TEST_D:   rdNext = RST_TEST_D;
            default: begin
               for (int p = 0; p < NUM_PORTS; p++) begin
                  if (regAddr == OFS_Q3_RATE[p]) rdNext = {1'b0, q3Reg[p]};
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rdReg <= RST_BYTE;
         rvReg <= 1'b0;
      end else begin
         rdReg <= rdNext;
         rvReg <= rvNext;
      end
   end

   assign regRdata  = rdReg;
   assign regRvalid = rvReg;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   a_test_fixed: assert property (
      regRead && regAddr == OFS_TEST_RSV |=> regRvalid && regRdata == RST_TEST_RSV)
      else $error("reserved control register did not read its fixed value");

   a_test_c_fixed: assert property (
      regRead && regAddr == OFS_TEST_C |=> regRdata == RST_TEST_C)
      else $error("test register C did not read its fixed value");

   // The bus strobes are one cycle apart at best, so the read follows two cycles later.
   a_q3_readback: assert property (
      regWrite && regAddr == OFS_Q3_RATE[0] ##2 regRead && regAddr == OFS_Q3_RATE[0]
      |=> regRdata == {1'b0, $past(regWdata[6:0], 3)})
      else $error("queue 3 rate code did not read back");

   // Rate code register, then the egress copy: two flops after the write.
   a_q3_to_egress: assert property (
      regWrite && regAddr == OFS_Q3_RATE[3]
      |-> ##3 egressCfg[3].q3Rate == $past(regWdata[6:0], 3))
      else $error("egress rate did not follow the rate code");

   a_prio_mode: assert property (
      ##1 egressCfg[1].q3Highest == $past(fourQueueMode[1]))
      else $error("queue 3 priority flag wrong");

   a_ratio_use: assert property (
      ##1 egressCfg[2].lowerFromRatio == $past(multiQueue[2]))
      else $error("ratio use flag wrong");

   a_static_launch: assert property (
      launchNow && ctrlReg[7:5] == 3'b000 && ctrlReg[3:0] == 4'h0 && regWdata <= 8'h1F
      |=> indReqValid && indReq.space == SP_STATIC && indReq.index == {2'b00, $past(regWdata)})
      else $error("static table access not launched");

   a_mib_port4: assert property (
      launchNow && ctrlReg[7:5] == 3'b000 && ctrlReg[3:0] == 4'hC && regWdata[7:5] == 3'b100
      |=> indReqValid && indReq.space == SP_MIB_PORT && indReq.port == PORT_LAST)
      else $error("port 4 MIB block misdecoded");

   a_eee_port: assert property (
      launchNow && ctrlReg[7:5] == 3'b001 && ctrlReg[3:0] == 4'h2 && regWdata <= EEE_LAST
      |=> indReqValid && indReq.space == SP_EEE && indReq.port == 4'h2)
      else $error("EEE access misdecoded");

   a_factory_block: assert property (
      launchNow && (ctrlReg[7:5] == 3'b011 || ctrlReg[7:5] == 3'b101)
      |=> !indReqValid)
      else $error("factory space reached an engine");

   a_rsv_read_zero: assert property (
      launchNow && ctrlReg[CTRL_READ_BIT] && decodeIndirect(ctrlReg, regWdata).space == SP_NONE
      ##2 (regRead && regAddr == OFS_IND_DATA && !regWrite) |=> regRdata == 8'h00)
      else $error("reserved read did not return zero");

   a_data_capture: assert property (
      pendReg && indRdValid && !launchNow && !(regWrite && regAddr == OFS_IND_DATA)
      |=> dataReg == $past(indRdata) && !pendReg)
      else $error("indirect read data not captured");

   c_static_read: cover property (indReqValid && indReq.space == SP_STATIC && !indReq.write);
   c_acl_write:   cover property (indReqValid && indReq.space == SP_ACL && indReq.write);
   c_rsv_access:  cover property (launchNow && launch.space == SP_NONE);
   c_data_return: cover property (pendReg && indRdValid);

endmodule : indirect_table_access_map

//--- testbench/table_engine_model.sv
// Purpose: Behavioural table engine that answers indirect reads of the register bank.
// Assumes: One outstanding read at a time; slow selects a long answer delay.
// Notes:   Read data is a function of the request so the bench can predict it.
`timescale 1ns/10ps
module table_engine_model
   import indirect_table_access_map_pkg::*;
(
   input  wire logic     sys_clk,
   input  wire logic     nrst,
   input  wire ind_req_t indReq,
   input  wire logic     indReqValid,
   input  wire logic     slow,
   output logic [7:0]    indRdata,
   output logic          indRdValid
);
   logic [4:0] waitCnt;
   logic [7:0] answer;

   initial begin
      indRdValid = 1'b0;
      indRdata   = 8'h00;
   end

   always @(posedge sys_clk) begin
      indRdValid <= 1'b0;
      // Off-pulse data is inverted so a capture in the wrong cycle shows up.
      indRdata   <= ~answer;
      if (!nrst) begin
         waitCnt <= 5'h00;
         answer  <= 8'h00;
      end else if (indReqValid && !indReq.write && indReq.space != SP_NONE) begin
         answer  <= indReq.index[7:0] ^ {indReq.port, 4'h5};
         waitCnt <= slow ? 5'h0F : 5'h01;
      end else if (waitCnt == 5'h01) begin
         indRdValid <= 1'b1;
         indRdata   <= answer;
         waitCnt    <= 5'h00;
      end else if (waitCnt != 5'h00) begin
         waitCnt <= waitCnt - 5'h01;
      end
   end
endmodule : table_engine_model

//--- testbench/indirect_table_access_map_tb_top.sv
// Purpose: Self-checking bench for the register bank and indirect decoder.
// Assumes: Engine model answers reads; bench drives the register strobes.
// Notes:   Expected data is rebuilt from the request, never from the design.
`timescale 1ns/10ps
module indirect_table_access_map_tb_top
   import indirect_table_access_map_pkg::*;
;
   localparam int         LIMIT       = 20000;
   localparam logic [7:0] TST_OFS [5] = '{OFS_TEST_A, OFS_TEST_RSV, OFS_TEST_B,
                                          OFS_TEST_C, OFS_TEST_D};
   localparam logic [7:0] TST_RST [5] = '{8'h80, 8'h15, 8'h0C, 8'h32, 8'h00};
   logic                        sys_clk, nrst, regWrite, regRead, regRvalid, slow;
   logic                        indReqValid, indRdValid;
   logic [7:0]                  regAddr, regWdata, regRdata, indRdata;
   logic [NUM_PORTS-1:0]        fourQueueMode, multiQueue;
   ind_req_t                    indReq;
   egress_cfg_t [NUM_PORTS-1:0] egressCfg;
   int                          n_mismatch, compares, cyc;

   indirect_table_access_map DUT (.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .regRvalid(regRvalid), .indReq(indReq), .indReqValid(indReqValid),
      .indRdata(indRdata), .indRdValid(indRdValid), .fourQueueMode(fourQueueMode),
      .multiQueue(multiQueue), .egressCfg(egressCfg));
   table_engine_model engine (.sys_clk(sys_clk), .nrst(nrst), .indReq(indReq),
      .indReqValid(indReqValid), .slow(slow), .indRdata(indRdata), .indRdValid(indRdValid));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic final_report();
      if (n_mismatch == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_mismatch++;
         final_report();
      end
   end

   function automatic logic [7:0] engData(input logic [3:0] pn, input logic [9:0] idx);
      return idx[7:0] ^ {pn, 4'h5};
   endfunction : engData

   task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: value %h expected %h", $time, got, exp);
      end
   endtask : chkVal

   task automatic chkReq(input ind_req_t got, input ind_req_t exp);
      compares++;
      if (got[26:8] !== exp[26:8] || (exp.write && got.wdata !== exp.wdata)) begin
         n_mismatch++;
         $display("mismatch at %0t: request %h expected %h", $time, got, exp);
      end
   endtask : chkReq

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge sys_clk);
      regWrite <= 1'b0;
   endtask : wr

   // Read data is taken one cycle after the strobe, together with the valid pulse.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      #1;
      d = regRvalid ? regRdata : 8'hXX;
   endtask : rd

   task automatic launch(input logic [7:0] ctrl, input logic [7:0] low, input logic [7:0] wd,
                         input space_t sp, input logic [3:0] pn, input logic [9:0] idx);
      ind_req_t   e;
      logic [7:0] d;
      logic       seen;
      e    = '{sp, !ctrl[4], pn, idx, wd};
      seen = 1'b0;
      wr(OFS_IND_CTRL, ctrl);
      if (!ctrl[4]) begin
         wr(OFS_IND_DATA, wd);
      end
      wr(OFS_IND_ADDR, low);
      #1;
      chkVal({15'h0000, indReqValid}, {15'h0000, sp != SP_NONE});
      if (sp != SP_NONE) begin
         chkReq(indReq, e);
      end
      if (ctrl[4]) begin
         for (int i = 0; i < 40 && sp != SP_NONE && !seen; i++) begin
            @(posedge sys_clk);
            #1;
            seen = (indRdValid === 1'b1);
         end
         rd(OFS_IND_DATA, d);
         chkVal(d, (sp == SP_NONE) ? 8'h00 : engData(pn, idx));
      end
   endtask : launch

   initial begin
      logic [7:0] d;
      logic [7:0] lo;
      logic [6:0] rate [NUM_PORTS];
      logic [3:0] fqm;
      logic [3:0] mq;
      void'($urandom(42280));
      {nrst, regWrite, regRead, slow} = 4'h0;
      {regAddr, regWdata} = 16'h0000;
      {fourQueueMode, multiQueue} = 8'h00;
      repeat (12) @(posedge sys_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         wr(TST_OFS[i], 8'h5A);
         rd(TST_OFS[i], d);
         chkVal(d, TST_RST[i]);
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
         rd(OFS_Q3_RATE[p], d);
         chkVal(d, 8'h00);
         rate[p] = (p == 0) ? 7'h7F : 7'($urandom);
         wr(OFS_Q3_RATE[p], {1'b1, rate[p]});
         rd(OFS_Q3_RATE[p], d);
         chkVal(d, {1'b0, rate[p]});
      end
      for (int k = 0; k < 4; k++) begin
         fqm = 4'($urandom);
         mq  = 4'($urandom);
         @(posedge sys_clk);
         fourQueueMode <= fqm;
         multiQueue    <= mq;
         repeat (2) @(posedge sys_clk);
         #1;
         for (int p = 0; p < NUM_PORTS; p++) begin
            chkVal(egressCfg[p], {rate[p], fqm[p], mq[p]});
         end
      end
      launch(8'h10, 8'h1F, 8'h00, SP_STATIC, 4'h0, 10'h01F);
      launch(8'h10, 8'h20, 8'h00, SP_NONE, 4'h0, 10'h000);
      launch(8'h15, 8'hFF, 8'h00, SP_VLAN, 4'h0, 10'h1FF);
      launch(8'h16, 8'h00, 8'h00, SP_NONE, 4'h0, 10'h000);
      launch(8'h19, 8'hFF, 8'h00, SP_DYNAMIC, 4'h0, 10'h1FF);
      launch(8'h1C, 8'h45, 8'h00, SP_MIB_PORT, 4'h3, 10'h045);
      launch(8'h1C, 8'h60, 8'h00, SP_NONE, 4'h0, 10'h000);
      launch(8'h1C, 8'h80, 8'h00, SP_MIB_PORT, 4'h4, 10'h080);
      launch(8'h1D, 8'h13, 8'h00, SP_MIB_TOTAL, 4'h0, 10'h113);
      launch(8'h1D, 8'h14, 8'h00, SP_NONE, 4'h0, 10'h000);
      launch(8'h32, 8'h05, 8'h00, SP_EEE, 4'h2, 10'h005);
      launch(8'h32, 8'h06, 8'h00, SP_NONE, 4'h0, 10'h000);
      launch(8'h21, 8'h03, 8'hC3, SP_EEE, 4'h1, 10'h003);
      launch(8'h54, 8'h1F, 8'h00, SP_ACL, 4'h4, 10'h01F);
      launch(8'h54, 8'h20, 8'h00, SP_NONE, 4'h0, 10'h000);
      launch(8'h71, 8'h00, 8'h00, SP_NONE, 4'h0, 10'h000);
      launch(8'hB1, 8'h00, 8'h00, SP_NONE, 4'h0, 10'h000);
      launch(8'h94, 8'h00, 8'h00, SP_NONE, 4'h0, 10'h000);
      for (int k = 0; k < 6; k++) begin
         slow <= k[0];
         lo = 8'($urandom_range(31));
         launch(8'h10, lo, 8'h00, SP_STATIC, 4'h0, {2'b00, lo});
         lo = 8'($urandom);
         launch({6'h24, 2'(k)}, lo, 8'h00, SP_CONFIG, {2'b00, 2'(k)}, {2'b00, lo});
      end
      final_report();
   end
endmodule : indirect_table_access_map_tb_top
